// *** src/uie_pkg.sv ***
// Constants, codes and carrier types for the UART interrupt enable logic.
// Assumes a single 20 MHz device clock and an 8-bit register port.
package uie_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_HOLD = 4'h0;     // Receive read, transmit write
  localparam logic [3:0] OFS_MASK = 4'h1;
  localparam logic [3:0] OFS_SRC_FCTL = 4'h2; // Source read, fifo control write
  localparam logic [3:0] OFS_LINE = 4'h5;
  localparam logic [3:0] OFS_MODEM = 4'h6;
  localparam logic [3:0] OFS_TRIG_CNT = 4'h8; // Trigger write, count read
  localparam logic [3:0] OFS_FEAT = 4'h9;
  localparam logic [3:0] OFS_ENH = 4'hA;
  localparam logic [3:0] OFS_SUMMARY = 4'hB;
  localparam logic [3:0] OFS_RES1 = 4'hC;
  localparam logic [3:0] OFS_RES2 = 4'hD;
  localparam logic [3:0] OFS_PAU1 = 4'hE;
  localparam logic [3:0] OFS_PAU2 = 4'hF;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MSK_RX = 0;
  localparam int MSK_TX = 1;
  localparam int MSK_LINE = 2;
  localparam int MSK_MODEM = 3;
  localparam int MSK_SLEEP = 4;
  localparam int MSK_XOFF = 5;
  localparam int MSK_RTS = 6;
  localparam int MSK_CTS = 7;
  localparam int ENH_ENABLE = 4;
  localparam int FCTL_FIFO_EN = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [3:0] MASK_ENH_BITS = 4'hF;

  // ----------------------------------------------------------------
  // Trigger selection and levels
  // ----------------------------------------------------------------
  localparam logic [1:0] TABLE_PROG = 2'h3;   // Feature bits 5:4 pick programmed level
  localparam logic [7:0] TRIG_A0 = 8'h01;
  localparam logic [7:0] TRIG_A1 = 8'h04;
  localparam logic [7:0] TRIG_A2 = 8'h08;
  localparam logic [7:0] TRIG_A3 = 8'h0E;
  localparam logic [7:0] TX_TRIG_DEF = 8'h01;

  // ----------------------------------------------------------------
  // Interrupt source codes, bits 5:0
  // ----------------------------------------------------------------
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_TMO = 6'h0C;
  localparam logic [5:0] SRC_RX = 6'h04;
  localparam logic [5:0] SRC_TX = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_XOFF = 6'h10;
  localparam logic [5:0] SRC_FLOW = 6'h20;
  localparam logic [5:0] SRC_NONE = 6'h01;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] level;     // Characters in receive fifo
    logic [7:0] head;      // Character at receive holding register
    logic [2:0] err_type;  // Break, framing, parity of head character
    logic overrun;         // Pulse: overrun seen
    logic fifo_err;        // Any fifo character carries an error
    logic loaded;          // Pulse: character moved into fifo
    logic timeout;         // Receive time-out level
  } uie_rx_stat_t;

  typedef struct packed {
    logic [7:0] level;     // Characters in transmit fifo
    logic hold_empty;      // Transmit holding register empty
    logic all_empty;       // Fifo and shift register empty
  } uie_tx_stat_t;

endpackage

// *** src/uie_top.sv ***
// Interrupt enable, source priority and line status for one UART channel.
// Assumes the datapath shares clk_i; the clear-to-send pin is asynchronous.
`timescale 1ns/1ps

// Contract
// - Mask register gates rx, tx, line and modem sources into the source register.
// - Fifo mode: rx interrupt while fifo level is at or above trigger.
// - Source code and interrupt both drop once level falls below trigger.
// - Data ready sets on a character load, clears only when fifo empty.
// - Fifo on and mask bits 0-3 clear gives polled operation via status.
// - Line status bit 1 is overrun, bits 2-4 error type of head character.
// - Bit 5 holding empty, bit 6 all transmit empty, bit 7 fifo error.
// - Mask bit 0, reset 0, enables receive data ready interrupt.
// - Mask bit 1, reset 0, enables transmit ready interrupt.
// - Enabling transmit ready interrupts at once while holding register empty (fifo off) or transmit level below trigger (fifo on).
// - Mask bit 2 enables line interrupt when status bits 1-4 set on receipt.
// - Mask bit 3, reset 0, enables modem status interrupt.
// - Mask bit 4 enables sleep; changeable only with enhanced enable set.
// - Mask bit 5 enables received pause character interrupt, enhanced only.
// - Mask bit 6 enables interrupt on request-to-send output rising.
// - Mask bit 7 enables interrupt on clear-to-send input rising.
// - Source register read returns the highest-priority pending code.
// - Source bit 0 reads 1 with nothing pending, 0 otherwise.
// - Line status read clears a pending line interrupt.
// - Source read while transmit is the reported code, or holding write, clears a pending transmit interrupt.
module uie_top #(
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Datapath status
  input wire uie_pkg::uie_rx_stat_t rx_i,
  input wire uie_pkg::uie_tx_stat_t tx_i,
  input wire logic [7:0] modem_i,
  input wire logic modem_delta_i,
  input wire logic pause_rx_i,
  input wire logic resume_rx_i,
  input wire logic rts_n_i,
  // Pins
  input wire logic cts_n_i,
  output logic irq_o,
  // Datapath controls
  output logic sleep_en_o,
  output logic fifo_en_o,
  output logic rx_pop_o,
  output logic tx_push_o,
  output logic [7:0] tx_data_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DW != 8)
  begin : g_bad_width
    $error("uie_top supports only an 8-bit register port");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] interrupt_mask_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] fifo_trigger_level_write;
  logic [7:0] resume_char_one;
  logic [7:0] resume_char_two;
  logic [7:0] pause_char_one;
  logic [7:0] pause_char_two;

  // Pending flags and history
  logic data_ready;
  logic overrun_flag;
  logic line_pend;
  logic tx_pend;
  logic modem_pend;
  logic pause_pend;
  logic flow_pend;
  logic tx_cond_q;
  logic rts_n_q;
  logic cts_meta;
  logic cts_sync;
  logic cts_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic wr_hold = wr_i && (addr_i == uie_pkg::OFS_HOLD);
  wire logic wr_mask = wr_i && (addr_i == uie_pkg::OFS_MASK);
  wire logic wr_fctl = wr_i && (addr_i == uie_pkg::OFS_SRC_FCTL);
  wire logic wr_trig = wr_i && (addr_i == uie_pkg::OFS_TRIG_CNT);
  wire logic wr_feat = wr_i && (addr_i == uie_pkg::OFS_FEAT);
  wire logic wr_enh = wr_i && (addr_i == uie_pkg::OFS_ENH);
  wire logic rd_hold = rd_i && (addr_i == uie_pkg::OFS_HOLD);
  wire logic rd_src = rd_i && (addr_i == uie_pkg::OFS_SRC_FCTL);
  wire logic rd_line = rd_i && (addr_i == uie_pkg::OFS_LINE);
  wire logic rd_modem = rd_i && (addr_i == uie_pkg::OFS_MODEM);

  // ----------------------------------------------------------------
  // Mode and trigger selection
  // ----------------------------------------------------------------
  wire logic fifo_mode = fifo_control_reg[uie_pkg::FCTL_FIFO_EN];
  wire logic enh_on = enhanced_feature_reg[uie_pkg::ENH_ENABLE];
  wire logic prog_trig = (feature_control_reg[5:4] == uie_pkg::TABLE_PROG);
  wire logic [7:0] table_trig = (fifo_control_reg[7:6] == 2'h0) ? uie_pkg::TRIG_A0 :
                                (fifo_control_reg[7:6] == 2'h1) ? uie_pkg::TRIG_A1 :
                                (fifo_control_reg[7:6] == 2'h2) ? uie_pkg::TRIG_A2 :
                                uie_pkg::TRIG_A3;
  wire logic [7:0] rx_trig = prog_trig ? fifo_trigger_level_write : table_trig;
  wire logic [7:0] tx_trig = prog_trig ? fifo_trigger_level_write : uie_pkg::TX_TRIG_DEF;

  // ----------------------------------------------------------------
  // Source conditions
  // ----------------------------------------------------------------
  // Level compare
  wire logic rx_at_trig = (rx_i.level >= rx_trig);
  wire logic rx_cond = fifo_mode ? rx_at_trig : data_ready;
  wire logic tx_cond = fifo_mode ? (tx_i.level < tx_trig) : tx_i.hold_empty;
  wire logic line_err = rx_i.overrun || (rx_i.err_type != 3'h0);
  wire logic line_set = rx_i.loaded && line_err;
  wire logic tx_enable_now = wr_mask && wdata_i[uie_pkg::MSK_TX]
                             && !interrupt_mask_reg[uie_pkg::MSK_TX];
  wire logic tx_set = (tx_cond && !tx_cond_q) || (tx_enable_now && tx_cond);
  wire logic rts_rise = rts_n_i && !rts_n_q;
  wire logic cts_rise = cts_sync && !cts_q;

  // ----------------------------------------------------------------
  // Enabled sources
  // ----------------------------------------------------------------
  // Mask gating
  wire logic en_line = line_pend && interrupt_mask_reg[uie_pkg::MSK_LINE];
  wire logic en_tmo = fifo_mode && rx_i.timeout && interrupt_mask_reg[uie_pkg::MSK_RX];
  wire logic en_rx = rx_cond && interrupt_mask_reg[uie_pkg::MSK_RX];
  wire logic en_tx = tx_pend && interrupt_mask_reg[uie_pkg::MSK_TX];
  wire logic en_modem = modem_pend && interrupt_mask_reg[uie_pkg::MSK_MODEM];
  wire logic en_pause = enh_on && pause_pend && interrupt_mask_reg[uie_pkg::MSK_XOFF];
  wire logic en_flow = enh_on && flow_pend;
  wire logic any_pend = en_line || en_tmo || en_rx || en_tx || en_modem
                        || en_pause || en_flow;

  // ----------------------------------------------------------------
  // Priority encode
  // ----------------------------------------------------------------
  // Highest level wins
  wire logic [5:0] src_code = en_line ? uie_pkg::SRC_LINE :
                              en_tmo ? uie_pkg::SRC_TMO :
                              en_rx ? uie_pkg::SRC_RX :
                              en_tx ? uie_pkg::SRC_TX :
                              en_modem ? uie_pkg::SRC_MODEM :
                              en_pause ? uie_pkg::SRC_XOFF :
                              en_flow ? uie_pkg::SRC_FLOW :
                              uie_pkg::SRC_NONE;
  wire logic [7:0] src_byte = {fifo_mode, fifo_mode, src_code};
  wire logic tx_is_top = (src_code == uie_pkg::SRC_TX);

  // ----------------------------------------------------------------
  // Status bytes
  // ----------------------------------------------------------------
  // Overrun and error type
  wire logic [7:0] line_byte = {rx_i.fifo_err, tx_i.all_empty, tx_i.hold_empty,
                                rx_i.err_type, overrun_flag, data_ready};
  wire logic [7:0] summary_byte = {3'h0, ~rx_cond, 3'h0, ~tx_cond};
  wire logic [7:0] next_mask = {enh_on ? wdata_i[7:4] :
                                interrupt_mask_reg[7:4] & uie_pkg::MASK_ENH_BITS,
                                wdata_i[3:0]};

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb
  begin
    case (addr_i)
      uie_pkg::OFS_HOLD: next_rdata = rx_i.head;
      uie_pkg::OFS_MASK: next_rdata = interrupt_mask_reg;
      uie_pkg::OFS_SRC_FCTL: next_rdata = src_byte;
      uie_pkg::OFS_LINE: next_rdata = line_byte;
      uie_pkg::OFS_MODEM: next_rdata = modem_i;
      uie_pkg::OFS_TRIG_CNT: next_rdata = rx_i.level;
      uie_pkg::OFS_FEAT: next_rdata = feature_control_reg;
      uie_pkg::OFS_ENH: next_rdata = enhanced_feature_reg;
      uie_pkg::OFS_SUMMARY: next_rdata = summary_byte;
      uie_pkg::OFS_RES1: next_rdata = resume_char_one;
      uie_pkg::OFS_RES2: next_rdata = resume_char_two;
      uie_pkg::OFS_PAU1: next_rdata = pause_char_one;
      uie_pkg::OFS_PAU2: next_rdata = pause_char_two;
      default: next_rdata = uie_pkg::READ_ZERO;
    endcase
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rdata_o <= uie_pkg::RST_BYTE;
    else
      rdata_o <= rd_i ? next_rdata : uie_pkg::READ_ZERO;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Mask register
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      interrupt_mask_reg <= uie_pkg::RST_BYTE;
    else if (wr_mask)
      interrupt_mask_reg <= next_mask;
  end

  // Fifo control write clears the whole register unless enable is written with it
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      fifo_control_reg <= uie_pkg::RST_BYTE;
    else if (wr_fctl)
      fifo_control_reg <= wdata_i[uie_pkg::FCTL_FIFO_EN] ? wdata_i : uie_pkg::RST_BYTE;
  end

  // Trigger, feature and enhanced registers
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      fifo_trigger_level_write <= uie_pkg::RST_BYTE;
      feature_control_reg <= uie_pkg::RST_BYTE;
      enhanced_feature_reg <= uie_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_trig)
        fifo_trigger_level_write <= wdata_i;
      if (wr_feat)
        feature_control_reg <= wdata_i;
      if (wr_enh)
        enhanced_feature_reg <= wdata_i;
    end
  end

  // Flow control characters
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      resume_char_one <= uie_pkg::RST_BYTE;
      resume_char_two <= uie_pkg::RST_BYTE;
      pause_char_one <= uie_pkg::RST_BYTE;
      pause_char_two <= uie_pkg::RST_BYTE;
    end
    else if (wr_i)
    begin
      if (addr_i == uie_pkg::OFS_RES1)
        resume_char_one <= wdata_i;
      if (addr_i == uie_pkg::OFS_RES2)
        resume_char_two <= wdata_i;
      if (addr_i == uie_pkg::OFS_PAU1)
        pause_char_one <= wdata_i;
      if (addr_i == uie_pkg::OFS_PAU2)
        pause_char_two <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
      cts_q <= 1'b1;
      rts_n_q <= 1'b1;
      tx_cond_q <= 1'b0;
    end
    else
    begin
      cts_meta <= cts_n_i;
      cts_sync <= cts_meta;
      cts_q <= cts_sync;
      rts_n_q <= rts_n_i;
      tx_cond_q <= tx_cond;
    end
  end

  // ----------------------------------------------------------------
  // Receive status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      data_ready <= 1'b0;
      overrun_flag <= 1'b0;
      line_pend <= 1'b0;
    end
    else
    begin
      if (rx_i.loaded)
        data_ready <= 1'b1;
      else if (rx_i.level == 8'h00)
        data_ready <= 1'b0;
      if (rx_i.overrun)
        overrun_flag <= 1'b1;
      else if (rd_line)
        overrun_flag <= 1'b0;
      if (line_set)
        line_pend <= 1'b1;
      else if (rd_line)
        line_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit and modem flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      tx_pend <= 1'b0;
      modem_pend <= 1'b0;
    end
    else
    begin
      if (tx_set)
        tx_pend <= 1'b1;
      else if ((rd_src && tx_is_top) || wr_hold)
        tx_pend <= 1'b0;
      if (modem_delta_i)
        modem_pend <= 1'b1;
      else if (rd_modem)
        modem_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Enhanced source flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pause_pend <= 1'b0;
      flow_pend <= 1'b0;
    end
    else
    begin
      // Pause set, resume or source read reporting the pause code clears
      if (pause_rx_i)
        pause_pend <= 1'b1;
      else if (resume_rx_i || (rd_src && src_code == uie_pkg::SRC_XOFF))
        pause_pend <= 1'b0;
      if ((rts_rise && interrupt_mask_reg[uie_pkg::MSK_RTS])
          || (cts_rise && interrupt_mask_reg[uie_pkg::MSK_CTS]))
        flow_pend <= 1'b1;
      else if (rd_modem)
        flow_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      irq_o <= 1'b0;
      sleep_en_o <= 1'b0;
      fifo_en_o <= 1'b0;
      rx_pop_o <= 1'b0;
      tx_push_o <= 1'b0;
      tx_data_o <= uie_pkg::RST_BYTE;
    end
    else
    begin
      irq_o <= any_pend;
      sleep_en_o <= interrupt_mask_reg[uie_pkg::MSK_SLEEP];
      fifo_en_o <= fifo_mode;
      rx_pop_o <= rd_hold;
      tx_push_o <= wr_hold;
      if (wr_hold)
        tx_data_o <= wdata_i;
    end
  end

endmodule

// *** sim/uie_top_chk.sv ***
// Port assertions for uie_top.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module uie_top_chk #(
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Status and pins
  input wire uie_pkg::uie_rx_stat_t rx_i,
  input wire uie_pkg::uie_tx_stat_t tx_i,
  input wire logic [7:0] modem_i,
  input wire logic modem_delta_i,
  input wire logic pause_rx_i,
  input wire logic resume_rx_i,
  input wire logic rts_n_i,
  input wire logic cts_n_i,
  // Outputs
  input wire logic irq_o,
  input wire logic sleep_en_o,
  input wire logic fifo_en_o,
  input wire logic rx_pop_o,
  input wire logic tx_push_o,
  input wire logic [7:0] tx_data_o
);
  // ------------------------------
  // Shadow of mask and trigger
  // ------------------------------
  logic [3:0] msk;
  logic [1:0] rsel;
  logic enh;
  logic [7:0] trig;
  wire mask_wr = wr_i && addr_i == uie_pkg::OFS_MASK;
  wire hold_wr = wr_i && addr_i == uie_pkg::OFS_HOLD;
  wire fctl_wr = wr_i && addr_i == uie_pkg::OFS_SRC_FCTL;
  wire bad_char = rx_i.loaded && (rx_i.overrun || rx_i.err_type != 3'h0);
  // Receive trigger from the table select
  assign trig = rsel[1] ? (rsel[0] ? uie_pkg::TRIG_A3 : uie_pkg::TRIG_A2)
    : (rsel[0] ? uie_pkg::TRIG_A1 : uie_pkg::TRIG_A0);
  // Follow register writes
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      msk <= 4'h0;
      rsel <= 2'h0;
      enh <= 1'b0;
    end
    else
    begin
      if (mask_wr)
        msk <= wdata_i[3:0];
      if (fctl_wr)
        rsel <= wdata_i[0] ? wdata_i[7:6] : 2'h0;
      if (wr_i && addr_i == uie_pkg::OFS_ENH)
        enh <= wdata_i[uie_pkg::ENH_ENABLE];
    end
  end
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside an answer");
  // Mask register then output flop: two cycles from write to pin
  chk_sleep_gate: assert property ($changed(sleep_en_o)
    |-> $past(mask_wr && enh, 2))
    else $error("sleep enable moved without unlocked mask write");
  chk_pop_cause: assert property (rx_pop_o |-> $past(rd_i && addr_i == uie_pkg::OFS_HOLD))
    else $error("receive pop without holding read");
  chk_push_data: assert property (hold_wr |=> tx_push_o && tx_data_o == $past(wdata_i))
    else $error("holding write not passed on");
  chk_fifo_bit: assert property (fctl_wr |-> ##2 fifo_en_o == $past(wdata_i[0], 2))
    else $error("fifo enable does not follow write");
  chk_rx_trig: assert property (fifo_en_o && msk[0] && rx_i.level >= trig |=> irq_o)
    else $error("no interrupt at receive trigger");
  chk_line_irq: assert property (msk[2] && bad_char && !mask_wr |-> ##2 irq_o)
    else $error("no interrupt on errored character");
  chk_tx_enable: assert property (mask_wr && wdata_i[1] && !msk[1] && !fifo_en_o
    && tx_i.hold_empty |-> ##[1:2] irq_o)
    else $error("no interrupt when enabling transmit ready");
  cov_rx_trig: cover property (fifo_en_o && msk[0] && rx_i.level >= trig);
  cov_line_rd: cover property (rd_i && addr_i == uie_pkg::OFS_LINE && irq_o);
  cov_sleep: cover property ($rose(sleep_en_o));
endmodule

bind uie_top uie_top_chk #(.DW(DW)) uie_top_chk_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_i(tx_i), .modem_i(modem_i),
  .modem_delta_i(modem_delta_i), .pause_rx_i(pause_rx_i), .resume_rx_i(resume_rx_i),
  .rts_n_i(rts_n_i), .cts_n_i(cts_n_i), .irq_o(irq_o), .sleep_en_o(sleep_en_o),
  .fifo_en_o(fifo_en_o), .rx_pop_o(rx_pop_o), .tx_push_o(tx_push_o), .tx_data_o(tx_data_o)
);

// *** sim/uie_host_mdl.sv ***
// Host model driving the register port.
// Assumes strobes change right after rising edges.
`timescale 1ns/1ps
module uie_host_mdl (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  // Idle bus from time zero
  initial
  begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Read data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

// *** sim/tb_uie_top.sv ***
// Testbench for uie_top: corner and random status traffic.
// Assumes uie_host_mdl as register master.
`timescale 1ns/1ps
module tb_uie_top;
  logic clk_i, nrst_i, wr_i, rd_i, irq_o, sleep_en_o, fifo_en_o, rx_pop_o, tx_push_o;
  logic resume_rx_i;
  logic [3:0] addr_i, ev;
  logic [7:0] wdata_i, rdata_o, tx_data_o, lvl;
  logic [31:0] seed;
  uie_pkg::uie_rx_stat_t rx_i;
  uie_pkg::uie_tx_stat_t tx_i;
  int err_count, n_compared, k;
  localparam logic [7:0] MASKS [4] = '{8'h08, 8'h20, 8'h40, 8'h80};
  localparam logic [5:0] CODES [4] = '{uie_pkg::SRC_MODEM, uie_pkg::SRC_XOFF,
    uie_pkg::SRC_FLOW, uie_pkg::SRC_FLOW};
  // Events: pins idle high, rise on release
  wire modem_delta_i = ev[0];
  wire pause_rx_i = ev[1];
  wire rts_n_i = ~ev[2];
  wire cts_n_i = ~ev[3];

  uie_host_mdl uie_host_mdl_inst (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
  uie_top #(.DW(8)) uie_top_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_i(tx_i), .modem_i(8'hB5),
    .modem_delta_i(modem_delta_i), .pause_rx_i(pause_rx_i), .resume_rx_i(resume_rx_i),
    .rts_n_i(rts_n_i), .cts_n_i(cts_n_i), .irq_o(irq_o), .sleep_en_o(sleep_en_o),
    .fifo_en_o(fifo_en_o), .rx_pop_o(rx_pop_o), .tx_push_o(tx_push_o), .tx_data_o(tx_data_o)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] src_byte(input logic f, input logic [5:0] c);
    return {f, f, c};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
    n_compared++;
    if (seen !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    uie_host_mdl_inst.rd(a, d);
    chk(nm, d, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    uie_host_mdl_inst.wr(a, d);
  endtask
  // Bounded wait for the interrupt level
  task automatic irq_chk(input logic e);
    int n;
    n = 0;
    while (irq_o !== e && n < 8)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("irq", {7'h00, irq_o}, {7'h00, e});
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    err_count++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    nrst_i = 1'b0;
    ev = 4'h0;
    resume_rx_i = 1'b0;
    rx_i = '0;
    tx_i = '0;
    tx_i.hold_empty = 1'b1;
    seed = 32'h15B9;
    err_count = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk("mask", uie_pkg::OFS_MASK, 8'h00);
    rd_chk("source", uie_pkg::OFS_SRC_FCTL, src_byte(1'b0, uie_pkg::SRC_NONE));
    rd_chk("unmapped", 4'h3, 8'h00);
    $display("test reset done");
    wr(uie_pkg::OFS_MASK, 8'hF0);
    rd_chk("locked mask", uie_pkg::OFS_MASK, 8'h00);
    wr(uie_pkg::OFS_ENH, 8'h10);
    wr(uie_pkg::OFS_MASK, 8'h10);
    rd_chk("sleep mask", uie_pkg::OFS_MASK, 8'h10);
    chk("sleep", {7'h00, sleep_en_o}, 8'h01);
    $display("test enhanced gate done");
    for (k = 0; k < 2; k++)
    begin
      wr(uie_pkg::OFS_MASK, 8'h00);
      wr(uie_pkg::OFS_MASK, 8'h02);
      irq_chk(1'b1);
      if (k == 0)
        rd_chk("tx source", uie_pkg::OFS_SRC_FCTL, src_byte(1'b0, uie_pkg::SRC_TX));
      else
        wr(uie_pkg::OFS_HOLD, 8'h5A);
      irq_chk(1'b0);
    end
    chk("tx data", tx_data_o, 8'h5A);
    $display("test transmit ready done");
    wr(uie_pkg::OFS_MASK, 8'h00);
    wr(uie_pkg::OFS_SRC_FCTL, 8'h41);
    wr(uie_pkg::OFS_MASK, 8'h01);
    for (k = 0; k < 24; k++)
    begin
      seed = lfsr_next(seed);
      lvl = (k < 2) ? 8'h03 + 8'(k) : {4'h0, seed[3:0]};
      @(posedge clk_i);
      rx_i.level <= lvl;
      repeat (3) @(posedge clk_i);
      chk("rx irq", {7'h00, irq_o}, {7'h00, lvl >= uie_pkg::TRIG_A1});
    end
    @(posedge clk_i);
    rx_i.level <= 8'h04;
    rd_chk("rx source", uie_pkg::OFS_SRC_FCTL, src_byte(1'b1, uie_pkg::SRC_RX));
    @(posedge clk_i);
    rx_i.level <= 8'h03;
    rd_chk("rx clear", uie_pkg::OFS_SRC_FCTL, src_byte(1'b1, uie_pkg::SRC_NONE));
    $display("test receive trigger done");
    wr(uie_pkg::OFS_MASK, 8'h00);
    @(posedge clk_i);
    rx_i.level <= 8'h09;
    // A character load is what sets data ready, not the level alone
    rx_i.loaded <= 1'b1;
    @(posedge clk_i);
    rx_i.loaded <= 1'b0;
    repeat (2) @(posedge clk_i);
    irq_chk(1'b0);
    rd_chk("polled line", uie_pkg::OFS_LINE, 8'h21);
    chk("fifo en", {7'h00, fifo_en_o}, 8'h01);
    wr(uie_pkg::OFS_MASK, 8'h04);
    @(posedge clk_i);
    rx_i.loaded <= 1'b1;
    rx_i.overrun <= 1'b1;
    rx_i.err_type <= 3'h2;
    rx_i.fifo_err <= 1'b1;
    rx_i.head <= 8'h3C;
    @(posedge clk_i);
    rx_i.loaded <= 1'b0;
    rx_i.overrun <= 1'b0;
    irq_chk(1'b1);
    rd_chk("line", uie_pkg::OFS_LINE, 8'hAB);
    irq_chk(1'b0);
    @(posedge clk_i);
    rx_i.level <= 8'h00;
    rd_chk("line empty", uie_pkg::OFS_LINE, 8'hA8);
    rd_chk("head", uie_pkg::OFS_HOLD, 8'h3C);
    $display("test line status done");
    for (k = 0; k < 4; k++)
    begin
      wr(uie_pkg::OFS_MASK, MASKS[k]);
      @(posedge clk_i);
      ev[k] <= 1'b1;
      repeat (3) @(posedge clk_i);
      ev[k] <= 1'b0;
      irq_chk(1'b1);
      rd_chk("event source", uie_pkg::OFS_SRC_FCTL, src_byte(1'b1, CODES[k]));
      @(posedge clk_i);
      resume_rx_i <= 1'b1;
      @(posedge clk_i);
      resume_rx_i <= 1'b0;
      rd_chk("modem", uie_pkg::OFS_MODEM, 8'hB5);
      irq_chk(1'b0);
    end
    $display("test events done");
    end_sim();
  end
endmodule
